// ### src/rfcpa_ctrl.sv
// Channel frequency, band divider and amplifier ramp control.
// Assumes command strobes come from logic on clk; registers on an 8-bit port.
// Function
// RL1: Carrier equals (integer plus fraction over 2^19) times twice reference over divider.
// RL2: Host keeps fraction over 2^19 between 1 and 2.
// RL3: Divider 24, 12, 8 or 4 selects the matching output band.
// RL4: Transmit frequency is base plus channel number times channel step size.
// RL5: Base frequency from integer and fraction settings is channel zero.
// RL6: Start argument sets channel; omitted argument keeps the stored channel.
// RL7: Stored channel starts at zero after reset.
// RL8: External ramp output off by default, enabled by amplifier type bit 7.
// RL9: External ramp rises and falls exactly with the internal amplifier ramp.
// RL10: Four-bit speed code selects ramp time from 2.0 to 20.0 us.
// RL11: Amplifier ramps up at transmit start and down at its end automatically.
// RL12: Fine power level gives 128 selectable output power settings.
// RL13: Crystal load tuning has 127 steps of 70 fF.
// RL14: With external clock, host zeroes crystal tuning and boots with external reference.
// RL15: Host gives the actual crystal frequency at boot if not 30 MHz.
// RL16: Synthesizer word is computed and loaded before the ramp-up starts.
// RL17: Each amplifier property is an eight-bit read-write value.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

module rfcpa_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Transmit commands
  input wire logic tx_start,
  input wire logic tx_has_channel,
  input wire logic [7:0] tx_channel,
  input wire logic tx_stop,
  // Synthesizer
  output logic [7:0] synth_int,
  output logic [19:0] synth_frac,
  output logic synth_load,
  output logic [4:0] band_divider,
  // Amplifier
  output logic [6:0] pa_ramp_level,
  output logic [6:0] external_amp_ramp_out,
  output logic [6:0] pa_power_level,
  output logic [7:0] pa_coarse,
  output logic tx_busy,
  // Crystal
  output logic [6:0] xtal_tune
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] amplifier_type_config;
  logic [7:0] power_fine_level;
  logic [7:0] power_coarse_bias_duty;
  logic [7:0] amplifier_ramp_time;
  logic [7:0] integer_divide_word;
  logic [19:0] fraction_divide_word;
  logic [15:0] step_size;
  logic [1:0] band_sel;
  logic [7:0] channel;
  logic [6:0] crystal_load_tuning;
  // State names of the package, local to this module
  localparam rfcpa_pkg::rfcpa_state_type S_IDLE = rfcpa_pkg::S_IDLE;
  localparam rfcpa_pkg::rfcpa_state_type S_CALC = rfcpa_pkg::S_CALC;
  localparam rfcpa_pkg::rfcpa_state_type S_LOAD = rfcpa_pkg::S_LOAD;
  localparam rfcpa_pkg::rfcpa_state_type S_UP = rfcpa_pkg::S_UP;
  localparam rfcpa_pkg::rfcpa_state_type S_ON = rfcpa_pkg::S_ON;
  localparam rfcpa_pkg::rfcpa_state_type S_DOWN = rfcpa_pkg::S_DOWN;
  rfcpa_pkg::rfcpa_state_type state;
  rfcpa_pkg::rfcpa_state_type next_state;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amplifier_type_config <= rfcpa_pkg::RST_AMP_TYPE; // [RL8]
      power_fine_level <= rfcpa_pkg::RST_PWR_FINE;
      power_coarse_bias_duty <= rfcpa_pkg::RST_PWR_COARSE;
      amplifier_ramp_time <= rfcpa_pkg::RST_RAMP_TIME;
      integer_divide_word <= rfcpa_pkg::RST_INT_WORD;
      fraction_divide_word <= rfcpa_pkg::RST_FRAC;
      step_size <= rfcpa_pkg::RST_STEP;
      band_sel <= rfcpa_pkg::RST_BAND_SEL;
      crystal_load_tuning <= rfcpa_pkg::RST_XTAL_TUNE;
    end else if (reg_write) begin
      case (reg_addr)
        rfcpa_pkg::ADDR_AMP_TYPE: amplifier_type_config <= reg_wdata; // [RL17]
        rfcpa_pkg::ADDR_PWR_FINE: power_fine_level <= reg_wdata; // [RL17]
        rfcpa_pkg::ADDR_PWR_COARSE: power_coarse_bias_duty <= reg_wdata; // [RL17]
        rfcpa_pkg::ADDR_RAMP_TIME: amplifier_ramp_time <= reg_wdata; // [RL17]
        rfcpa_pkg::ADDR_INT_WORD: integer_divide_word <= reg_wdata;
        rfcpa_pkg::ADDR_FRAC_HIGH: fraction_divide_word[19:16] <= reg_wdata[3:0];
        rfcpa_pkg::ADDR_FRAC_MID: fraction_divide_word[15:8] <= reg_wdata;
        rfcpa_pkg::ADDR_FRAC_LOW: fraction_divide_word[7:0] <= reg_wdata;
        rfcpa_pkg::ADDR_STEP_HIGH: step_size[15:8] <= reg_wdata;
        rfcpa_pkg::ADDR_STEP_LOW: step_size[7:0] <= reg_wdata;
        rfcpa_pkg::ADDR_BAND_SEL: band_sel <= reg_wdata[1:0];
        rfcpa_pkg::ADDR_XTAL_TUNE: crystal_load_tuning <= reg_wdata[6:0]; // [RL13]
        default: ;
      endcase
    end
  end

  // Stored channel: start argument or register write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel <= rfcpa_pkg::RST_CHANNEL; // [RL7]
    end else if (tx_start && tx_has_channel && state == S_IDLE) begin
      channel <= tx_channel; // [RL6]
    end else if (reg_write && reg_addr == rfcpa_pkg::ADDR_CHANNEL) begin
      channel <= reg_wdata;
    end
  end

  // Read data for one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        rfcpa_pkg::ADDR_AMP_TYPE: reg_rdata <= amplifier_type_config; // [RL17]
        rfcpa_pkg::ADDR_PWR_FINE: reg_rdata <= power_fine_level;
        rfcpa_pkg::ADDR_PWR_COARSE: reg_rdata <= power_coarse_bias_duty;
        rfcpa_pkg::ADDR_RAMP_TIME: reg_rdata <= amplifier_ramp_time;
        rfcpa_pkg::ADDR_INT_WORD: reg_rdata <= integer_divide_word;
        rfcpa_pkg::ADDR_FRAC_HIGH: reg_rdata <= {4'h0, fraction_divide_word[19:16]};
        rfcpa_pkg::ADDR_FRAC_MID: reg_rdata <= fraction_divide_word[15:8];
        rfcpa_pkg::ADDR_FRAC_LOW: reg_rdata <= fraction_divide_word[7:0];
        rfcpa_pkg::ADDR_STEP_HIGH: reg_rdata <= step_size[15:8];
        rfcpa_pkg::ADDR_STEP_LOW: reg_rdata <= step_size[7:0];
        rfcpa_pkg::ADDR_BAND_SEL: reg_rdata <= {6'h00, band_sel};
        rfcpa_pkg::ADDR_CHANNEL: reg_rdata <= channel;
        rfcpa_pkg::ADDR_XTAL_TUNE: reg_rdata <= {1'b0, crystal_load_tuning};
        rfcpa_pkg::ADDR_STATUS: reg_rdata <= {5'h00, state == S_ON, state == S_UP, state == S_DOWN};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit sequence

  logic [6:0] ramp_level;
  logic [11:0] ramp_err;
  logic [11:0] ramp_len;
  logic stop_pending;
  logic [23:0] chan_offset;
  logic [27:0] next_word;
  logic [12:0] next_err;

  assign ramp_len = rfcpa_pkg::rfcpa_ramp_cycles(amplifier_ramp_time[3:0]); // [RL10]
  assign next_err = {1'b0, ramp_err} + 13'(rfcpa_pkg::RAMP_TOP);
  // Base at channel zero plus channel offset
  assign next_word = 28'({integer_divide_word, 19'h00000}) + 28'(fraction_divide_word)
                     + 28'(chan_offset); // [RL4] [RL5]

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (tx_start) next_state = S_CALC;
      S_CALC: next_state = S_LOAD;
      S_LOAD: next_state = S_UP; // [RL16]
      S_UP: if (ramp_level == rfcpa_pkg::RAMP_TOP) next_state = S_ON; // [RL11]
      S_ON: if (tx_stop || stop_pending) next_state = S_DOWN; // [RL11]
      S_DOWN: if (ramp_level == 7'h00) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Stop arriving before full power is kept until the ramp tops out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_pending <= 1'b0;
    end else if (state == S_ON || state == S_IDLE) begin
      stop_pending <= 1'b0;
    end else if (tx_stop) begin
      stop_pending <= 1'b1;
    end
  end

  // Channel offset ahead of the synthesizer load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_offset <= 24'h000000;
    end else if (state == S_CALC) begin
      chan_offset <= 24'(channel) * 24'(step_size); // [RL4] [RL16]
    end
  end

  // Synthesizer word, fraction kept in [2^19, 2^20)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      synth_int <= rfcpa_pkg::RST_INT_WORD - 8'h01;
      synth_frac <= rfcpa_pkg::RST_FRAC;
      synth_load <= 1'b0;
    end else begin
      synth_load <= state == S_LOAD; // [RL16]
      if (state == S_LOAD) begin
        synth_int <= 8'(next_word[27:rfcpa_pkg::FRAC_POINT] - 9'h001); // [RL1]
        synth_frac <= {1'b1, next_word[18:0]}; // [RL1]
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      band_divider <= rfcpa_pkg::DIV_BAND3;
    end else begin
      case (band_sel)
        2'h0: band_divider <= rfcpa_pkg::DIV_BAND0; // [RL3]
        2'h1: band_divider <= rfcpa_pkg::DIV_BAND1; // [RL3]
        2'h2: band_divider <= rfcpa_pkg::DIV_BAND2; // [RL3]
        default: band_divider <= rfcpa_pkg::DIV_BAND3; // [RL3]
      endcase
    end
  end

  // Linear ramp: one level step whenever the error passes the ramp length
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ramp_level <= 7'h00;
      ramp_err <= 12'h000;
    end else if (state == S_UP || state == S_DOWN) begin
      if (next_err >= {1'b0, ramp_len}) begin
        ramp_err <= 12'(next_err - {1'b0, ramp_len});
        ramp_level <= state == S_UP ? ramp_level + 7'h01 : ramp_level - 7'h01; // [RL10]
      end else begin
        ramp_err <= next_err[11:0];
      end
    end else begin
      ramp_err <= 12'h000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_ramp_level <= 7'h00;
      external_amp_ramp_out <= 7'h00;
    end else begin
      pa_ramp_level <= ramp_level; // [RL11]
      external_amp_ramp_out <= amplifier_type_config[rfcpa_pkg::EXT_RAMP_BIT] ? ramp_level : 7'h00; // [RL8] [RL9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pa_power_level <= 7'h00;
      pa_coarse <= 8'h00;
      xtal_tune <= 7'h00;
      tx_busy <= 1'b0;
    end else begin
      pa_power_level <= power_fine_level[6:0]; // [RL12]
      pa_coarse <= power_coarse_bias_duty;
      xtal_tune <= crystal_load_tuning; // [RL13]
      tx_busy <= next_state != S_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Cycles spent ramping up, held at the top instead of wrapping
  logic [11:0] up_cycles;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cycles <= 12'h000;
    end else if (state != S_UP) begin
      up_cycles <= 12'h000;
    end else if (up_cycles != 12'hfff) begin
      up_cycles <= up_cycles + 12'h001;
    end
  end

  a_ext_ramp_off: assert property (@(posedge clk) disable iff (rst) // [RL8]
    !amplifier_type_config[rfcpa_pkg::EXT_RAMP_BIT] |=> external_amp_ramp_out == 7'h00)
    else $error("External ramp driven while disabled");

  a_ext_ramp_same: assert property (@(posedge clk) disable iff (rst) // [RL9]
    $past(amplifier_type_config[rfcpa_pkg::EXT_RAMP_BIT]) |-> external_amp_ramp_out == pa_ramp_level)
    else $error("External ramp differs from amplifier ramp");

  a_ramp_top: assert property (@(posedge clk) disable iff (rst) // [RL10]
    state == S_UP && next_state == S_ON |-> ramp_level == rfcpa_pkg::RAMP_TOP && ramp_err == 12'h000)
    else $error("Ramp left early or late");

  // Ramp-up duration against the shortest and longest codes
  a_ramp_bounded: assert property (@(posedge clk) disable iff (rst) // [RL10]
    state == S_UP |-> up_cycles <= rfcpa_pkg::rfcpa_ramp_cycles(4'hf))
    else $error("Ramp up time out of range");

  a_ramp_min: assert property (@(posedge clk) disable iff (rst) // [RL10]
    state == S_UP && next_state == S_ON |-> up_cycles >= rfcpa_pkg::rfcpa_ramp_cycles(4'h0))
    else $error("Ramp up ended too soon");

  a_stop_kept: assert property (@(posedge clk) disable iff (rst) // [RL11]
    state == S_ON && stop_pending |=> state == S_DOWN)
    else $error("Early stop not applied at full ramp");

  a_load_first: assert property (@(posedge clk) disable iff (rst) // [RL16]
    synth_load |-> state == S_UP && ramp_level == 7'h00 && pa_ramp_level == 7'h00)
    else $error("Synthesizer loaded after ramp start");

  a_auto_down: assert property (@(posedge clk) disable iff (rst) // [RL11]
    state == S_ON && tx_stop |=> state == S_DOWN)
    else $error("Stop did not start ramp down");

  a_chan_take: assert property (@(posedge clk) disable iff (rst) // [RL6]
    state == S_IDLE && tx_start && tx_has_channel |=> channel == $past(tx_channel))
    else $error("Channel argument not stored");

  a_chan_keep: assert property (@(posedge clk) disable iff (rst) // [RL6]
    tx_start && !tx_has_channel && !reg_write |=> $stable(channel))
    else $error("Channel changed without argument");

  a_synth_word: assert property (@(posedge clk) disable iff (rst) // [RL4]
    synth_load |-> {synth_int + 8'h01, synth_frac[18:0]} == 27'(next_word))
    else $error("Synthesizer word mismatch");

  a_band_div: assert property (@(posedge clk) disable iff (rst) // [RL3]
    band_sel == 2'h1 |=> band_divider == 5'h0c)
    else $error("Band divider mismatch");

  c_full_tx: cover property (@(posedge clk) disable iff (rst) state == S_DOWN ##1 state == S_IDLE);
  c_ext_ramp: cover property (@(posedge clk) disable iff (rst) external_amp_ramp_out == rfcpa_pkg::RAMP_TOP);
  c_chan_start: cover property (@(posedge clk) disable iff (rst) tx_start && tx_has_channel && state == S_IDLE);
  c_early_stop: cover property (@(posedge clk) disable iff (rst) state == S_UP && tx_stop);
  c_chan_reg: cover property (@(posedge clk) disable iff (rst) reg_write && reg_addr == rfcpa_pkg::ADDR_CHANNEL);

endmodule

// ### src/rfcpa_pkg.sv
// Constants of the channel and amplifier ramp control block.
// Assumes a 100 MHz clock and an 8-bit register port with 16-bit addresses.
package rfcpa_pkg;

  // Register offsets
  localparam logic [15:0] ADDR_AMP_TYPE = 16'h2200;
  localparam logic [15:0] ADDR_PWR_FINE = 16'h2201;
  localparam logic [15:0] ADDR_PWR_COARSE = 16'h2202;
  localparam logic [15:0] ADDR_RAMP_TIME = 16'h2203;
  localparam logic [15:0] ADDR_INT_WORD = 16'h2000;
  localparam logic [15:0] ADDR_FRAC_HIGH = 16'h2001;
  localparam logic [15:0] ADDR_FRAC_MID = 16'h2002;
  localparam logic [15:0] ADDR_FRAC_LOW = 16'h2003;
  localparam logic [15:0] ADDR_STEP_HIGH = 16'h2004;
  localparam logic [15:0] ADDR_STEP_LOW = 16'h2005;
  localparam logic [15:0] ADDR_BAND_SEL = 16'h2006;
  localparam logic [15:0] ADDR_CHANNEL = 16'h2007;
  localparam logic [15:0] ADDR_XTAL_TUNE = 16'h1000;
  localparam logic [15:0] ADDR_STATUS = 16'h3000;

  // Field positions
  localparam int EXT_RAMP_BIT = 7;
  localparam int FRAC_POINT = 19;

  // Values after reset
  localparam logic [7:0] RST_AMP_TYPE = 8'h08;
  localparam logic [7:0] RST_PWR_FINE = 8'h7f;
  localparam logic [7:0] RST_PWR_COARSE = 8'h00;
  localparam logic [7:0] RST_RAMP_TIME = 8'h05;
  localparam logic [7:0] RST_INT_WORD = 8'h3c;
  localparam logic [19:0] RST_FRAC = 20'h80000;
  localparam logic [15:0] RST_STEP = 16'h0000;
  localparam logic [1:0] RST_BAND_SEL = 2'h3;
  localparam logic [7:0] RST_CHANNEL = 8'h00;
  localparam logic [6:0] RST_XTAL_TUNE = 7'h00;

  // Output divider per band select
  localparam logic [4:0] DIV_BAND0 = 5'h18;
  localparam logic [4:0] DIV_BAND1 = 5'h0c;
  localparam logic [4:0] DIV_BAND2 = 5'h08;
  localparam logic [4:0] DIV_BAND3 = 5'h04;

  // Ramp timing: table in tenths of a microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_UNIT_NS = 100;
  localparam int CYC_PER_UNIT = (RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] RAMP_TOP = 7'h7f;

  typedef enum {
    S_IDLE, S_CALC, S_LOAD, S_UP, S_ON, S_DOWN
  } rfcpa_state_type;

  function automatic logic [11:0] rfcpa_ramp_cycles(input logic [3:0] code);
    logic [7:0] tenths;
    tenths = 8'h14;
    case (code)
      4'h0: tenths = 8'h14;
      4'h1: tenths = 8'h15;
      4'h2: tenths = 8'h16;
      4'h3: tenths = 8'h18;
      4'h4: tenths = 8'h1a;
      4'h5: tenths = 8'h1c;
      4'h6: tenths = 8'h1f;
      4'h7: tenths = 8'h22;
      4'h8: tenths = 8'h25;
      4'h9: tenths = 8'h29;
      4'ha: tenths = 8'h2d;
      4'hb: tenths = 8'h32;
      4'hc: tenths = 8'h3c;
      4'hd: tenths = 8'h50;
      4'he: tenths = 8'h64;
      default: tenths = 8'hc8;
    endcase
    return 12'(tenths * CYC_PER_UNIT);
  endfunction

endpackage

// ### bench/rfcpa_host_model.sv
// Host model: drives the register port and the transmit commands.
// Assumes a free-running clk; every pin changes just after a rising edge.
`timescale 1ns/1ns

module rfcpa_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Transmit commands
  output logic tx_start,
  output logic tx_has_channel,
  output logic [7:0] tx_channel,
  output logic tx_stop
);
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    tx_start = 1'b0;
    tx_has_channel = 1'b0;
    tx_channel = 8'h00;
    tx_stop = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles; released lines are inverted so stale values never look valid
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit commands
  task automatic start(input logic h, input logic [7:0] c);
    @(posedge clk);
    tx_start <= 1'b1;
    tx_has_channel <= h;
    tx_channel <= c;
    @(posedge clk);
    tx_start <= 1'b0;
    tx_has_channel <= ~h;
    tx_channel <= ~c;
  endtask

  task automatic stop();
    @(posedge clk);
    tx_stop <= 1'b1;
    @(posedge clk);
    tx_stop <= 1'b0;
  endtask

  // External reference in use: load bank cleared
  task automatic ext_ref();
    wr(rfcpa_pkg::ADDR_XTAL_TUNE, 8'h00);
  endtask
endmodule

// ### bench/rf_channel_and_pa_ramp_control_bench.sv
// Self-checking bench of the channel and amplifier ramp control block.
// Assumes the host model issues all commands; clock and reset made here.
`timescale 1ns/1ns

module rf_channel_and_pa_ramp_control_bench;
  logic clk, rst, reg_write, reg_read, tx_start, tx_has_channel, tx_stop, synth_load, tx_busy;
  logic [15:0] reg_addr, step;
  logic [7:0] reg_wdata, reg_rdata, tx_channel, synth_int, pa_coarse, inte, amp_type, chan, prev;
  logic [19:0] synth_frac, frac;
  logic [4:0] band_divider;
  logic [6:0] pa_ramp_level, external_amp_ramp_out, pa_power_level, xtal_tune;
  int fail_count = 0;
  int cmp_count = 0;

  rfcpa_ctrl uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_start(tx_start),
    .tx_has_channel(tx_has_channel), .tx_channel(tx_channel), .tx_stop(tx_stop),
    .synth_int(synth_int), .synth_frac(synth_frac), .synth_load(synth_load),
    .band_divider(band_divider), .pa_ramp_level(pa_ramp_level),
    .external_amp_ramp_out(external_amp_ramp_out), .pa_power_level(pa_power_level),
    .pa_coarse(pa_coarse), .tx_busy(tx_busy), .xtal_tune(xtal_tune));

  rfcpa_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_start(tx_start),
    .tx_has_channel(tx_has_channel), .tx_channel(tx_channel), .tx_stop(tx_stop));

  ////////////////////////////////////////////////////////////////////////////////
  // Checking and expectations
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic int ramp_len(input logic [3:0] c);
    int t[16] = '{20, 21, 22, 24, 26, 28, 31, 34, 37, 41, 45, 50, 60, 80, 100, 200};
    return t[c] * 10;
  endfunction

  // Frequency words assume the nominal reference; no crystal value is passed
  task automatic set_freq();
    inte = 8'h20 + 8'($urandom % 64);
    frac = 20'h80000 | 20'($urandom);
    step = 16'($urandom);
    host.wr(rfcpa_pkg::ADDR_INT_WORD, inte);
    host.wr(rfcpa_pkg::ADDR_FRAC_HIGH, {4'h0, frac[19:16]});
    host.wr(rfcpa_pkg::ADDR_FRAC_MID, frac[15:8]);
    host.wr(rfcpa_pkg::ADDR_FRAC_LOW, frac[7:0]);
    host.wr(rfcpa_pkg::ADDR_STEP_HIGH, step[15:8]);
    host.wr(rfcpa_pkg::ADDR_STEP_LOW, step[7:0]);
  endtask

  // Counts cycles to full ramp or to idle, comparing the external ramp each cycle
  task automatic watch(input logic want_top, output int n);
    n = 0;
    while (want_top ? pa_ramp_level !== 7'h7f : tx_busy !== 1'b0) begin
      @(posedge clk);
      #1 n++;
      check("ext", external_amp_ramp_out, amp_type[7] ? pa_ramp_level : 7'h00);
      if (n > 3000) begin
        fail_count++;
        results();
      end
    end
  endtask

  task automatic tx(input logic h, input logic [7:0] ch, input logic [7:0] ech, input logic [3:0] code);
    int n;
    logic [31:0] w;
    w = {inte, 19'h0} + frac + ech * step;
    host.start(h, ch);
    @(posedge clk);
    #1 check("busy", tx_busy, 1'b1);
    @(posedge clk);
    #1 check("load", synth_load, 1'b1);
    check("lvl", pa_ramp_level, 7'h00);
    check("int", synth_int, 8'(w[31:19] - 1));
    check("frac", synth_frac, {1'b1, w[18:0]});
    watch(1'b1, n);
    check("up", n >= ramp_len(code) - 3 && n <= ramp_len(code) + 6, 1'b1);
    host.start(1'b1, 8'hee);
    host.stop();
    watch(1'b0, n);
    check("down", n >= ramp_len(code) - 3 && n <= ramp_len(code) + 6, 1'b1);
    check("lvl0", pa_ramp_level, 7'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    int i, n;
    logic [7:0] v, d;
    static logic [7:0] rv[4] = '{rfcpa_pkg::RST_AMP_TYPE, rfcpa_pkg::RST_PWR_FINE,
      rfcpa_pkg::RST_PWR_COARSE, rfcpa_pkg::RST_RAMP_TIME};
    static logic [4:0] dv[4] = '{5'h18, 5'h0c, 5'h08, 5'h04};
    rst = 1'b1;
    i = $urandom(43);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      host.rd(rfcpa_pkg::ADDR_AMP_TYPE + 16'(i), v);
      check("rst", v, rv[i]);
    end
    host.rd(rfcpa_pkg::ADDR_CHANNEL, v);
    check("chan", v, 8'h00);
    host.rd(16'h2210, v);
    check("unmapped", v, 8'h00);
    @(posedge clk);
    #1 check("rdata", reg_rdata, 8'h00);
    for (i = 0; i < 16; i++) begin
      v = 8'($urandom);
      host.wr(rfcpa_pkg::ADDR_AMP_TYPE + 16'(i % 4), v);
      host.rd(rfcpa_pkg::ADDR_AMP_TYPE + 16'(i % 4), d);
      check("rw", d, v);
      if (i % 4 == 1) check("pwr", pa_power_level, v[6:0]);
      if (i % 4 == 2) check("coarse", pa_coarse, v);
    end
    v = 8'($urandom % 128);
    host.wr(rfcpa_pkg::ADDR_XTAL_TUNE, v);
    @(posedge clk);
    #1 check("xtal", xtal_tune, v[6:0]);
    host.ext_ref();
    @(posedge clk);
    #1 check("xtal0", xtal_tune, 7'h00);
    for (i = 0; i < 4; i++) begin
      host.wr(rfcpa_pkg::ADDR_BAND_SEL, 8'(i));
      @(posedge clk);
      #1 check("band", band_divider, dv[i]);
    end
    host.wr(rfcpa_pkg::ADDR_AMP_TYPE, 8'h08);
    host.wr(rfcpa_pkg::ADDR_RAMP_TIME, 8'h05);
    amp_type = 8'h08;
    prev = 8'h00;
    set_freq();
    tx(1'b0, 8'h00, 8'h00, 4'h5);
    for (i = 0; i < 16; i++) begin
      amp_type = {i[0], 7'($urandom)};
      host.wr(rfcpa_pkg::ADDR_AMP_TYPE, amp_type);
      host.wr(rfcpa_pkg::ADDR_RAMP_TIME, {4'($urandom), 4'(i)});
      set_freq();
      chan = (i == 15) ? 8'hff : 8'($urandom);
      if (i == 4) begin
        host.wr(rfcpa_pkg::ADDR_CHANNEL, chan);
        prev = chan;
      end
      tx(i[1], chan, i[1] ? chan : prev, 4'(i));
      if (i[1]) prev = chan;
    end
    host.start(1'b0, 8'h00);
    host.stop();
    watch(1'b1, n);
    watch(1'b0, n);
    check("early", n >= ramp_len(4'hf) - 3 && n <= ramp_len(4'hf) + 6, 1'b1);
    results();
  end
endmodule
